/* core/gps_pcs_top.sv */
`timescale 1ns/1ps
module gps_pcs_top
   import gps_pkg::*;
#(
   parameter bit HAS_EMBEDDED_PMA = 1'b0
)
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        tbi_tx_clk,
   input  wire logic        tbi_rx_clk,
   input  wire logic [9:0]  tbi_rx_d,
   output logic      [9:0]  tbi_tx_d,
   input  wire logic [9:0]  tx_code,
   input  wire logic        tx_en,
   input  wire logic        mode_sgmii,
   input  wire logic        an_enable,
   input  wire logic        sgmii_mac_mode,
   input  wire logic        full_duplex,
   input  wire logic        autoneg_done,
   input  wire logic [15:0] partner_ability,
   input  wire logic [15:0] dev_ability,
   input  wire logic        powerdown_req,
   input  wire logic        loopback_req,
   input  wire logic        ecc_corrected,
   input  wire logic        ecc_uncorrectable,
   input  wire logic        tx_cal_raw,
   input  wire logic        rx_cal_raw,
   input  wire logic        cdr_data_lock_raw,
   input  wire logic        cdr_ref_lock_raw,
   input  wire logic        force_lock_data,
   input  wire logic        force_lock_ref,
   input  wire logic        tx_analog_reset,
   input  wire logic        tx_digital_reset,
   input  wire logic        rx_analog_reset,
   input  wire logic        rx_digital_reset,
   output logic             led_link,
   output logic             led_panel_link,
   output logic             led_crs,
   output logic             led_col,
   output logic             autoneg_done_indicator,
   output logic             led_char_err,
   output logic             led_disp_err,
   output logic             powerdown,
   output logic             serdes_loop_control,
   output logic      [1:0]  pcs_ecc_status,
   output logic             tx_cal_busy,
   output logic             rx_cal_busy,
   output logic             locked_on_data,
   output logic             locked_on_reference
);

   // ----------------------------------------------------------------
   // State of the register clock domain
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SY_W-1:0] sy1;
      logic [SY_W-1:0] sy2;
      logic            link;
      logic            panel;
      logic            crs;
      logic            col;
      logic            an;
      logic            pd;
      logic            loop;
      logic [1:0]      ecc;
      logic            txcal;
      logic            rxcal;
      logic            lkd;
      logic            lkr;
   } gps_core_t;

   // State of the transmit clock domain
   typedef struct packed {
      logic       q1;
      logic       q2;
      logic [9:0] txd;
   } gps_tx_t;

   gps_core_t c_r;
   gps_core_t c_nxt;
   gps_tx_t   t_r;
   gps_tx_t   t_nxt;

   logic rx_sync;
   logic rx_crs;

   // ----------------------------------------------------------------
   // Receive alignment on the recovered clock
   // ----------------------------------------------------------------
   gps_rx_align u_rx (
      .tbi_rx_clk (tbi_rx_clk),
      .reset_n    (reset_n),
      .tbi_rx_d   (tbi_rx_d),
      .link_sync  (rx_sync),
      .rx_carrier (rx_crs),
      .char_err   (led_char_err),
      .disp_err   (led_disp_err)
   );

   // Panel link selection by operating mode
   function automatic logic panel_sel(input logic lk, input logic an,
                                      input logic [15:0] pa, input logic [15:0] da);
      logic r;
      if (!an_enable) begin
         r = lk;
      end else if (!mode_sgmii) begin
         r = an;
      end else if (sgmii_mac_mode) begin
         r = an && pa[ABIL_LINK_BIT];
      end else begin
         r = an && da[ABIL_LINK_BIT];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Register clock domain logic
   // ----------------------------------------------------------------
   always_comb begin
      logic sync_s;
      logic crs_s;
      logic rx_hold;
      sync_s  = c_r.sy2[SY_SYNC];
      crs_s   = c_r.sy2[SY_CRS];
      rx_hold = c_r.sy2[SY_RX_ARST] || c_r.sy2[SY_RX_DRST];
      c_nxt = c_r;
      // Pins and other-domain levels; only sy2 is ever read
      c_nxt.sy1 = {rx_crs, rx_sync, rx_digital_reset, rx_analog_reset,
                   tx_digital_reset, tx_analog_reset, cdr_ref_lock_raw,
                   cdr_data_lock_raw, rx_cal_raw, tx_cal_raw};
      c_nxt.sy2 = c_r.sy1;
      c_nxt.link  = sync_s;
      c_nxt.an    = autoneg_done;
      c_nxt.panel = panel_sel(sync_s, autoneg_done, partner_ability, dev_ability);
      c_nxt.crs   = crs_s || tx_en;
      // Plain Base-X and full duplex can never collide
      c_nxt.col   = mode_sgmii && !full_duplex && tx_en && crs_s;
      c_nxt.pd    = powerdown_req && !HAS_EMBEDDED_PMA;
      c_nxt.loop  = loopback_req;
      // Uncorrectable wins; the invalid code never leaves here
      if (ecc_uncorrectable) begin
         c_nxt.ecc = ECC_UNCORR;
      end else if (ecc_corrected) begin
         c_nxt.ecc = ECC_CORR;
      end else begin
         c_nxt.ecc = ECC_NONE;
      end
      // An analog reset shows calibration busy only while it is held
      c_nxt.txcal = c_r.sy2[SY_TX_CAL] || c_r.sy2[SY_TX_ARST];
      c_nxt.rxcal = c_r.sy2[SY_RX_CAL] || c_r.sy2[SY_RX_ARST];
      // A force to one target masks the other lock report
      c_nxt.lkd = c_r.sy2[SY_LK_DATA] && !force_lock_ref && !rx_hold;
      c_nxt.lkr = c_r.sy2[SY_LK_REF] && !force_lock_data && !rx_hold;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Transmit clock domain logic
   // ----------------------------------------------------------------
   always_comb begin
      t_nxt    = t_r;
      t_nxt.q1 = c_r.pd || c_r.sy2[SY_TX_DRST];
      t_nxt.q2 = t_r.q1;
      // Quiet bus while powered down or without a ten-bit port
      if (HAS_EMBEDDED_PMA || t_r.q2) begin
         t_nxt.txd = QUIET_WORD;
      end else begin
         t_nxt.txd = tx_code;
      end
   end

   always_ff @(posedge tbi_tx_clk or negedge reset_n) begin
      if (!reset_n) begin
         t_r <= '0;
      end else begin
         t_r <= t_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from flip-flops
   // ----------------------------------------------------------------
   assign tbi_tx_d               = t_r.txd;
   assign led_link               = c_r.link;
   assign led_panel_link         = c_r.panel;
   assign led_crs                = c_r.crs;
   assign led_col                = c_r.col;
   assign autoneg_done_indicator = c_r.an;
   assign powerdown              = c_r.pd;
   assign serdes_loop_control    = c_r.loop;
   assign pcs_ecc_status         = c_r.ecc;
   assign tx_cal_busy            = c_r.txcal;
   assign rx_cal_busy            = c_r.rxcal;
   assign locked_on_data         = c_r.lkd;
   assign locked_on_reference    = c_r.lkr;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_link_follows: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(c_r.sy2[SY_SYNC]) |=> led_link)
      else $error("link indicator lags sync");
   a_panel_noan: assert property (@(posedge clk) disable iff (!reset_n)
      !an_enable ##1 !$past(an_enable) |-> led_panel_link == $past(c_r.sy2[SY_SYNC]))
      else $error("panel link differs from sync");
   a_panel_basex: assert property (@(posedge clk) disable iff (!reset_n)
      (an_enable && !mode_sgmii) |=> led_panel_link == $past(autoneg_done))
      else $error("panel link differs from autoneg");
   a_panel_mac: assert property (@(posedge clk) disable iff (!reset_n)
      (an_enable && mode_sgmii && sgmii_mac_mode) |=>
      led_panel_link == ($past(autoneg_done) && $past(partner_ability[ABIL_LINK_BIT])))
      else $error("panel link wrong in mac mode");
   a_panel_phy: assert property (@(posedge clk) disable iff (!reset_n)
      (an_enable && mode_sgmii && !sgmii_mac_mode) |=>
      led_panel_link == ($past(autoneg_done) && $past(dev_ability[ABIL_LINK_BIT])))
      else $error("panel link wrong in phy mode");
   a_col_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      (!mode_sgmii || full_duplex) |=> !led_col)
      else $error("collision in base-x or full duplex");
   a_crs_tx: assert property (@(posedge clk) disable iff (!reset_n)
      tx_en |=> led_crs)
      else $error("carrier missing while sending");
   a_ecc_code: assert property (@(posedge clk) disable iff (!reset_n)
      ecc_uncorrectable |=> pcs_ecc_status == ECC_UNCORR ##0 pcs_ecc_status != 2'h1)
      else $error("ecc status wrong");
   a_loop_follow: assert property (@(posedge clk) disable iff (!reset_n)
      loopback_req ##1 loopback_req |-> serdes_loop_control)
      else $error("loop control not following");
   a_pd_quiet: assert property (@(posedge tbi_tx_clk) disable iff (!reset_n)
      (t_r.q2 [*2]) |-> tbi_tx_d == QUIET_WORD)
      else $error("transmit bus active in power-down");
   a_lock_force: assert property (@(posedge clk) disable iff (!reset_n)
      force_lock_data |=> !locked_on_reference)
      else $error("reference lock shown while forced to data");
   a_lock_ref_force: assert property (@(posedge clk) disable iff (!reset_n)
      force_lock_ref |=> !locked_on_data)
      else $error("data lock shown while forced to reference");
   a_lock_rx_reset: assert property (@(posedge clk) disable iff (!reset_n)
      (c_r.sy2[SY_RX_ARST] || c_r.sy2[SY_RX_DRST]) |=> !locked_on_data && !locked_on_reference)
      else $error("lock shown during receive reset");
   a_an_follow: assert property (@(posedge clk) disable iff (!reset_n)
      autoneg_done |=> autoneg_done_indicator)
      else $error("autoneg indicator not raised");
   a_an_clear: assert property (@(posedge clk) disable iff (!reset_n)
      !autoneg_done |=> !autoneg_done_indicator)
      else $error("autoneg indicator stuck");
   a_pd_follow: assert property (@(posedge clk) disable iff (!reset_n)
      powerdown_req |=> powerdown == !HAS_EMBEDDED_PMA)
      else $error("power-down output not following");
   a_loop_clear: assert property (@(posedge clk) disable iff (!reset_n)
      !loopback_req |=> !serdes_loop_control)
      else $error("loop control stuck");
   a_col_raise: assert property (@(posedge clk) disable iff (!reset_n)
      (mode_sgmii && !full_duplex && tx_en && c_r.sy2[SY_CRS]) |=> led_col)
      else $error("collision not flagged");
   a_crs_line: assert property (@(posedge clk) disable iff (!reset_n)
      c_r.sy2[SY_CRS] |=> led_crs)
      else $error("carrier missing with line traffic");
   a_ecc_corr: assert property (@(posedge clk) disable iff (!reset_n)
      (ecc_corrected && !ecc_uncorrectable) |=> pcs_ecc_status == ECC_CORR)
      else $error("corrected status wrong");
   a_txcal_busy: assert property (@(posedge clk) disable iff (!reset_n)
      c_r.sy2[SY_TX_CAL] |=> tx_cal_busy)
      else $error("transmit calibration not shown");
   a_rxcal_busy: assert property (@(posedge clk) disable iff (!reset_n)
      c_r.sy2[SY_RX_CAL] |=> rx_cal_busy)
      else $error("receive calibration not shown");
   c_panel_up: cover property (@(posedge clk) disable iff (!reset_n) $rose(led_panel_link));
   c_collision: cover property (@(posedge clk) disable iff (!reset_n) led_col);
   c_ecc_corr: cover property (@(posedge clk) disable iff (!reset_n)
      pcs_ecc_status == ECC_CORR);

endmodule

/* core/gps_pkg.sv */
package gps_pkg;

   // ----------------------------------------------------------------
   // Code group and comma constants
   // ----------------------------------------------------------------
   localparam int         CODE_W     = 10;
   localparam logic [6:0] COMMA_POS  = 7'h7C;   // First seven bits, bit 0 first on line
   localparam logic [6:0] COMMA_NEG  = 7'h03;
   localparam logic [9:0] K_SOP      = 10'h05B; // Start of packet, negative disparity form
   localparam logic [9:0] K_EOP      = 10'h05D; // End of packet, negative disparity form
   localparam logic [9:0] QUIET_WORD = 10'h000;
   localparam logic [3:0] ONES_MIN   = 4'h4;
   localparam logic [3:0] ONES_MAX   = 4'h6;
   localparam logic [3:0] OFF_LAST   = 4'h9;

   // ----------------------------------------------------------------
   // Word sync thresholds
   // ----------------------------------------------------------------
   localparam logic [2:0] CNT_ZERO   = 3'h0;
   localparam logic [2:0] CNT_ONE    = 3'h1;
   localparam logic [2:0] ACQ_COMMAS = 3'h3;
   localparam logic [2:0] LOSS_ERRS  = 3'h4;

   // ----------------------------------------------------------------
   // Status encodings and bit positions
   // ----------------------------------------------------------------
   localparam int         ABIL_LINK_BIT = 15;
   localparam logic [1:0] ECC_NONE      = 2'h0;
   localparam logic [1:0] ECC_CORR      = 2'h2;
   localparam logic [1:0] ECC_UNCORR    = 2'h3;

   // Slots of the pin synchroniser vector
   localparam int SY_W       = 10;
   localparam int SY_TX_CAL  = 0;
   localparam int SY_RX_CAL  = 1;
   localparam int SY_LK_DATA = 2;
   localparam int SY_LK_REF  = 3;
   localparam int SY_TX_ARST = 4;
   localparam int SY_TX_DRST = 5;
   localparam int SY_RX_ARST = 6;
   localparam int SY_RX_DRST = 7;
   localparam int SY_SYNC    = 8;
   localparam int SY_CRS     = 9;

   typedef enum logic [2:0] {
      GPS_LOSS = 3'h1,
      GPS_ACQ  = 3'h2,
      GPS_SYNC = 3'h4
   } gps_sync_t;

   // Number of ones in a code group
   function automatic logic [3:0] gps_ones(input logic [9:0] w);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < CODE_W; i++) begin
         n = n + {3'h0, w[i]};
      end
      return n;
   endfunction

   // Comma in either disparity at the head of a word
   function automatic logic gps_is_comma(input logic [9:0] w);
      return (w[6:0] == COMMA_POS) || (w[6:0] == COMMA_NEG);
   endfunction

   // Special code in either disparity
   function automatic logic gps_is_k(input logic [9:0] w, input logic [9:0] k);
      return (w == k) || (w == ~k);
   endfunction

endpackage

/* core/gps_rx_align.sv */
`timescale 1ns/1ps
module gps_rx_align
   import gps_pkg::*;
(
   input  wire logic       tbi_rx_clk,
   input  wire logic       reset_n,
   input  wire logic [9:0] tbi_rx_d,
   output logic            link_sync,
   output logic            rx_carrier,
   output logic            char_err,
   output logic            disp_err
);

   typedef struct packed {
      logic [9:0] prev;
      logic [3:0] off;
      logic [9:0] code;
      gps_sync_t  st;
      logic [2:0] cnt;
      logic       rd_pos;
      logic       crs;
      logic       cerr;
      logic       derr;
   } gps_rx_t;

   gps_rx_t s_r;
   gps_rx_t s_nxt;

   // ----------------------------------------------------------------
   // Comma search, realignment and code group checks
   // ----------------------------------------------------------------
   always_comb begin
      logic [19:0] win;
      logic        hit;
      logic [3:0]  hoff;
      logic [3:0]  ones;
      logic        bad;
      win   = {tbi_rx_d, s_r.prev};
      hit   = 1'b0;
      hoff  = s_r.off;
      ones  = gps_ones(s_r.code);
      bad   = (ones < ONES_MIN) || (ones > ONES_MAX);
      s_nxt = s_r;
      s_nxt.prev = tbi_rx_d;
      // Words arrive at any bit offset, so every offset is tried
      for (int k = 0; k < CODE_W; k++) begin
         if (!hit && gps_is_comma(win[k +: CODE_W])) begin
            hit  = 1'b1;
            hoff = 4'(k);
         end
      end
      // Lock the boundary once in sync; stray commas must not slip it
      if (s_r.st != GPS_SYNC && hit) begin
         s_nxt.off = hoff;
      end
      s_nxt.code = win[s_nxt.off +: CODE_W];
      // Unaligned words are not judged, so the reset code leaves no false pulse
      s_nxt.cerr = bad && (s_r.st != GPS_LOSS);
      s_nxt.derr = !bad && (s_r.st != GPS_LOSS) &&
                   ((ones == ONES_MAX && s_r.rd_pos) ||
                    (ones == ONES_MIN && !s_r.rd_pos));
      if (ones == ONES_MAX) begin
         s_nxt.rd_pos = 1'b1;
      end else if (ones == ONES_MIN) begin
         s_nxt.rd_pos = 1'b0;
      end
      unique case (s_r.st)
         GPS_LOSS: begin
            s_nxt.cnt = CNT_ONE;
            if (hit) begin
               s_nxt.st = GPS_ACQ;
            end
         end
         GPS_ACQ: begin
            if (bad) begin
               s_nxt.st = GPS_LOSS;
            end else if (hit && hoff == s_r.off) begin
               s_nxt.cnt = s_r.cnt + CNT_ONE;
               if (s_nxt.cnt == ACQ_COMMAS) begin
                  s_nxt.st  = GPS_SYNC;
                  s_nxt.cnt = CNT_ZERO;
               end
            end
         end
         GPS_SYNC: begin
            s_nxt.cnt = bad ? s_r.cnt + CNT_ONE : CNT_ZERO;
            if (s_nxt.cnt == LOSS_ERRS) begin
               s_nxt.st = GPS_LOSS;
            end
         end
      endcase
      // Carrier from packet delimiters while word-synchronised
      if (s_r.st != GPS_SYNC) begin
         s_nxt.crs = 1'b0;
      end else if (gps_is_k(s_r.code, K_SOP)) begin
         s_nxt.crs = 1'b1;
      end else if (gps_is_k(s_r.code, K_EOP)) begin
         s_nxt.crs = 1'b0;
      end
   end

   always_ff @(posedge tbi_rx_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{prev: QUIET_WORD, off: 4'h0, code: QUIET_WORD, st: GPS_LOSS,
                  cnt: CNT_ZERO, rd_pos: 1'b0, crs: 1'b0, cerr: 1'b0, derr: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link_sync  = (s_r.st == GPS_SYNC);
   assign rx_carrier = s_r.crs;
   assign char_err   = s_r.cerr;
   assign disp_err   = s_r.derr;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_char_err_pulse: assert property (@(posedge tbi_rx_clk) disable iff (!reset_n)
      (s_r.st != GPS_LOSS) &&
      ((gps_ones(s_r.code) < ONES_MIN) || (gps_ones(s_r.code) > ONES_MAX)) |=> char_err)
      else $error("char error not flagged");
   a_disp_err_excl: assert property (@(posedge tbi_rx_clk) disable iff (!reset_n)
      disp_err |-> !char_err)
      else $error("disparity and char error together");
   a_offset_held: assert property (@(posedge tbi_rx_clk) disable iff (!reset_n)
      link_sync |=> (s_r.off == $past(s_r.off)))
      else $error("boundary moved while in sync");
   a_offset_range: assert property (@(posedge tbi_rx_clk) disable iff (!reset_n)
      s_r.off <= OFF_LAST)
      else $error("alignment offset out of range");
   c_sync_reached: cover property (@(posedge tbi_rx_clk) disable iff (!reset_n)
      $rose(link_sync));
   c_disp_seen: cover property (@(posedge tbi_rx_clk) disable iff (!reset_n) disp_err);

endmodule

/* tb/gps_serdes_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External SERDES stand-in
// ----------------------------------------------------------------
module gps_serdes_model #(
   parameter int OFF = 3
)
(
   output logic            tbi_tx_clk,
   output logic            tbi_rx_clk,
   input  wire logic [9:0] rx_word,
   output logic      [9:0] tbi_rx_d
);
   logic [19:0] hist = 20'h0;

   // Both line clocks run free; only the receive clock is shifted off the core clock edges
   initial begin
      tbi_tx_clk = 1'b0;
      forever #24.0 tbi_tx_clk = ~tbi_tx_clk;
   end
   initial begin
      tbi_rx_clk = 1'b0;
      #1.3;
      forever #24.0 tbi_rx_clk = ~tbi_rx_clk;
   end

   // Words leave at a fixed odd bit offset, so the block cannot lean on framing
   always @(posedge tbi_rx_clk) begin
      hist <= {rx_word, hist[19:10]};
      tbi_rx_d <= hist[OFF +: 10];
   end
endmodule

/* tb/gigabit_pcs_tbi_status_port_tb_top.sv */
`timescale 1ns/1ps
module gigabit_pcs_tbi_status_port_tb_top
   import gps_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        tbi_tx_clk, tbi_rx_clk, tx_on = 1'b0;
   logic [9:0]  tbi_rx_d, tbi_tx_d, tx_code = 10'h000, last_code = 10'h000, rx_word = 10'h2AA;
   logic [19:0] st = 20'h00000;
   logic [15:0] pa = 16'h0000, da = 16'h0000;
   logic        led_link, led_panel_link, led_crs, led_col, autoneg_done_indicator;
   logic        led_char_err, led_disp_err, powerdown, serdes_loop_control;
   logic [1:0]  pcs_ecc_status;
   logic        tx_cal_busy, rx_cal_busy, locked_on_data, locked_on_reference;
   logic [9:0]  wq[$];
   logic [9:0]  slip_seq [6] = '{10'h17C, 10'h17C, 10'h283, 10'h3FF, 10'h17C, 10'h283};
   int          seed = 23712, num_errors = 0, n_checks = 0, n_char = 0, n_disp = 0, c0, d0;

   always #2.0 clk = ~clk;

   // ----------------------------------------------------------------
   // Block and far side
   // ----------------------------------------------------------------
   gps_pcs_top #(.HAS_EMBEDDED_PMA(1'b0)) gps_pcs_top_inst (
      .clk(clk), .reset_n(reset_n), .tbi_tx_clk(tbi_tx_clk), .tbi_rx_clk(tbi_rx_clk),
      .tbi_rx_d(tbi_rx_d), .tbi_tx_d(tbi_tx_d), .tx_code(tx_code), .tx_en(st[0]),
      .mode_sgmii(st[1]), .an_enable(st[2]), .sgmii_mac_mode(st[3]), .full_duplex(st[4]),
      .autoneg_done(st[5]), .partner_ability(pa), .dev_ability(da), .powerdown_req(st[6]),
      .loopback_req(st[7]), .ecc_corrected(st[8]), .ecc_uncorrectable(st[9]),
      .tx_cal_raw(st[10]), .rx_cal_raw(st[11]), .cdr_data_lock_raw(st[12]),
      .cdr_ref_lock_raw(st[13]), .force_lock_data(st[14]), .force_lock_ref(st[15]),
      .tx_analog_reset(st[16]), .tx_digital_reset(st[17]), .rx_analog_reset(st[18]),
      .rx_digital_reset(st[19]), .led_link(led_link), .led_panel_link(led_panel_link),
      .led_crs(led_crs), .led_col(led_col), .autoneg_done_indicator(autoneg_done_indicator),
      .led_char_err(led_char_err), .led_disp_err(led_disp_err), .powerdown(powerdown),
      .serdes_loop_control(serdes_loop_control), .pcs_ecc_status(pcs_ecc_status),
      .tx_cal_busy(tx_cal_busy), .rx_cal_busy(rx_cal_busy), .locked_on_data(locked_on_data),
      .locked_on_reference(locked_on_reference));

   gps_serdes_model #(.OFF(3)) gps_serdes_model_inst (
      .tbi_tx_clk(tbi_tx_clk), .tbi_rx_clk(tbi_rx_clk), .rx_word(rx_word),
      .tbi_rx_d(tbi_rx_d));

   // ----------------------------------------------------------------
   // Line traffic and pulse counting
   // ----------------------------------------------------------------
   // Filler alternates bits, so no comma can form across word edges
   always @(posedge tbi_rx_clk) begin
      if (wq.size() > 0)
         rx_word <= wq.pop_front();
      else
         rx_word <= 10'h2AA;
   end

   // Mid-cycle sampling, each high cycle counted once
   always @(negedge tbi_rx_clk) begin
      if (led_char_err === 1'b1) n_char++;
      if (led_disp_err === 1'b1) n_disp++;
   end

   // Transmit side: random code groups, one line clock of delay expected
   always @(posedge tbi_tx_clk) begin
      if (tx_on) begin
         last_code <= tx_code;
         tx_code <= 10'($random(seed));
      end
   end
   always @(negedge tbi_tx_clk) begin
      if (tx_on) chk("tbi_tx_d", tbi_tx_d, last_code);
   end

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Status model worked from the mode table; lk and cr are the line state
   task automatic check_status(input logic lk, input logic cr);
      logic rxr;
      logic pnl;
      rxr = st[18] | st[19];
      pnl = !st[2] ? lk : !st[1] ? st[5] : (st[3] ? st[5] & pa[15] : st[5] & da[15]);
      chk("led_link", led_link, lk);
      chk("panel", led_panel_link, pnl);
      chk("crs", led_crs, cr | st[0]);
      chk("col", led_col, st[1] & !st[4] & st[0] & cr);
      chk("an", autoneg_done_indicator, st[5]);
      chk("pdown", powerdown, st[6]);
      chk("loop", serdes_loop_control, st[7]);
      chk("ecc", pcs_ecc_status, st[9] ? 2'h3 : st[8] ? 2'h2 : 2'h0);
      chk("txcal", tx_cal_busy, st[10] | st[16]);
      chk("rxcal", rx_cal_busy, st[11] | st[18]);
      chk("lkdata", locked_on_data, st[12] & !st[15] & !rxr);
      chk("lkref", locked_on_reference, st[13] & !st[14] & !rxr);
   endtask

   // Bounded drain of queued words, then time for the pipeline and syncs
   task automatic settle();
      for (int i = 0; i < 200 && wq.size() > 0; i++) @(posedge clk);
      // A queue that never drains is a hang, counted as a mismatch
      if (wq.size() > 0) num_errors++;
      repeat (6) @(posedge tbi_rx_clk);
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic complete_run();
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #20000;
      num_errors++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      // Reset spans the slow line clocks, not only the core clock
      repeat (3) @(posedge tbi_rx_clk);
      @(posedge clk) reset_n <= 1'b1;
      // Random status pins, no word sync on the line
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         st <= 20'($random(seed));
         pa <= 16'($random(seed));
         da <= 16'($random(seed));
         repeat (7) @(posedge clk);
         #1;
         check_status(1'b0, 1'b0);
      end
      @(posedge clk) st <= 20'h00000;
      // Commas at an odd offset must bring word sync
      repeat (4) begin
         wq.push_back(10'h17C);
         wq.push_back(10'h283);
      end
      settle();
      check_status(1'b1, 1'b0);
      tx_on = 1'b1;
      c0 = n_char;
      d0 = n_disp;
      // Start of packet raises carrier; collision only half-duplex SGMII
      wq.push_back(K_SOP);
      settle();
      check_status(1'b1, 1'b1);
      @(posedge clk) st <= 20'h00003;
      settle();
      check_status(1'b1, 1'b1);
      @(posedge clk) st <= 20'h00013;
      settle();
      check_status(1'b1, 1'b1);
      @(posedge clk) st <= 20'h00000;
      wq.push_back(K_EOP);
      settle();
      check_status(1'b1, 1'b0);
      // One disparity slip, one bad character, sync held
      foreach (slip_seq[k])
         wq.push_back(slip_seq[k]);
      settle();
      chk("disp_pulses", 10'(n_disp - d0), 10'h001);
      chk("char_pulses", 10'(n_char - c0), 10'h001);
      check_status(1'b1, 1'b0);
      // Four bad words in a row lose sync
      repeat (4) wq.push_back(10'h3FF);
      settle();
      check_status(1'b0, 1'b0);
      tx_on = 1'b0;
      complete_run();
   end
endmodule
